// *** rtl/rps_map.vh ***
// constants for the receiver phase sequencer
`ifndef RPS_MAP_VH
`define RPS_MAP_VH

// ----------------------------------------------------------------
// clock and tick
// ----------------------------------------------------------------
`define RPS_CLK_HZ        100000000
`define RPS_MS_PER_S      1000
`define RPS_MS_CYCLES     17'h186A0
`define RPS_DIV_W         17
`define RPS_MS_W          8
`define RPS_MS_MAX        8'hFF

// ----------------------------------------------------------------
// phase timing, milliseconds
// ----------------------------------------------------------------
`define RPS_T_WAKE_MS     8'h28
`define RPS_T_SILENT_MS   8'h07
`define RPS_T_RSP_MS      8'h1E

// ----------------------------------------------------------------
// hold-off bounds, milliseconds (plain defaults)
// ----------------------------------------------------------------
`define RPS_HOLDOFF_MIN   8'h05
`define RPS_HOLDOFF_MAX   8'hCD

// ----------------------------------------------------------------
// packet kinds presented to the modulator
// ----------------------------------------------------------------
`define RPS_PKT_NONE      4'h0
`define RPS_PKT_SIGSTR    4'h1
`define RPS_PKT_ENDXFER   4'h2
`define RPS_PKT_IDENT     4'h3
`define RPS_PKT_XIDENT    4'h4
`define RPS_PKT_HOLDOFF   4'h5
`define RPS_PKT_PROP      4'h6
`define RPS_PKT_CONFIG    4'h7

// ----------------------------------------------------------------
// sequence limits and contract values
// ----------------------------------------------------------------
`define RPS_OPT_MAX       3'h6
`define RPS_GUAR_5W       6'h0A
`define RPS_RP_HDR_8BIT   8'h04
`define RPS_DEPTH_ZERO    2'h0
`define RPS_CNT_ONE       3'h1
`define RPS_CNT_ZERO      3'h0

`endif

// *** rtl/rps_ms_timer.v ***
// millisecond tick counter with restart, saturating
`include "rps_map.vh"

module rps_ms_timer #(
  parameter [`RPS_DIV_W-1:0] MS_CYCLES = `RPS_MS_CYCLES
) (
  input  wire                  ref_clk,
  input  wire                  reset_n,
  input  wire                  restart,
  output reg  [`RPS_MS_W-1:0]  ms_r
);

  reg [`RPS_DIV_W-1:0] div_r;

  // restart zeroes both stages so a window starts at its event
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= {`RPS_DIV_W{1'b0}};
      ms_r  <= {`RPS_MS_W{1'b0}};
    end else if (restart) begin
      div_r <= {`RPS_DIV_W{1'b0}};
      ms_r  <= {`RPS_MS_W{1'b0}};
    end else if (div_r == MS_CYCLES - 1'b1) begin
      div_r <= {`RPS_DIV_W{1'b0}};
      // saturate so long waits never wrap into a short window
      if (ms_r != `RPS_MS_MAX)
        ms_r <= ms_r + 1'b1;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

endmodule // rps_ms_timer

// *** rtl/rps_sequencer.v ***
// receiver phase sequencer: selection, ping, identification and configuration
`include "rps_map.vh"

module rps_sequencer #(
  parameter [`RPS_DIV_W-1:0] MS_CYCLES = `RPS_MS_CYCLES
) (
  input  wire                  ref_clk,
  input  wire                  reset_n,
  input  wire                  power_applied,
  input  wire                  power_removed,
  input  wire                  coil_half_rise,
  input  wire                  comm_ready,
  input  wire                  vr_ok,
  input  wire                  end_xfer_req,
  input  wire                  ext_id,
  input  wire                  foreign_object_extensions,
  input  wire                  max_power_over_5w,
  input  wire                  neg_opt_en,
  input  wire                  holdoff_en,
  input  wire [2:0]            opt_count,
  input  wire [7:0]            holdoff_req_ms,
  input  wire [5:0]            cfg_max_power,
  input  wire                  cfg_polarity,
  input  wire [1:0]            cfg_depth,
  input  wire                  pkt_done,
  input  wire                  ack_start,
  output reg  [6:0]            phase_r,
  output reg                   pkt_req_r,
  output reg  [3:0]            pkt_type_r,
  output reg                   cfg_neg_r,
  output reg                   cfg_pol_r,
  output reg  [1:0]            cfg_depth_r,
  output reg  [7:0]            holdoff_ms_r,
  output reg  [5:0]            con_guar_r,
  output reg  [5:0]            con_max_r,
  output reg  [7:0]            con_rp_hdr_r,
  output reg                   con_pol_r,
  output reg  [1:0]            con_depth_r,
  output reg  [5:0]            tmp_guar_r,
  output reg  [5:0]            tmp_max_r,
  output reg  [7:0]            tmp_rp_hdr_r,
  output reg                   tmp_pol_r,
  output reg  [1:0]            tmp_depth_r
);

  // ----------------------------------------------------------------
  // phase and step codes
  // ----------------------------------------------------------------
  localparam [6:0] PH_SEL = 7'h01;
  localparam [6:0] PH_PING = 7'h02;
  localparam [6:0] PH_IDCFG = 7'h04;
  localparam [6:0] PH_NEG = 7'h08;
  localparam [6:0] PH_CAL = 7'h10;
  localparam [6:0] PH_XFER = 7'h20;
  localparam [6:0] PH_RENEG = 7'h40;

  localparam [4:0] ST_ID = 5'h01;
  localparam [4:0] ST_XID = 5'h02;
  localparam [4:0] ST_OPT = 5'h04;
  localparam [4:0] ST_CFG = 5'h08;
  localparam [4:0] ST_WAIT = 5'h10;

  // ----------------------------------------------------------------
  // local state
  // ----------------------------------------------------------------
  reg  [4:0]           step_r;
  reg                  busy_r;
  reg                  rise_seen_r;
  reg  [2:0]           opt_done_r;
  wire [`RPS_MS_W-1:0] ms;
  wire                 restart;
  wire [2:0]           opt_limit;
  wire                 neg_want;
  wire                 spaced;

  // windows restart at coil crossings and packet ends
  assign restart   = coil_half_rise | power_removed | pkt_done;
  // preamble requested at the silent target; modulator starts header by 19 ms
  assign spaced    = !busy_r && (ms >= `RPS_T_SILENT_MS);
  // with extensions the only optional packet before configuration is a hold-off
  assign opt_limit = foreign_object_extensions ? {2'b00, holdoff_en}
                   : ((opt_count > `RPS_OPT_MAX) ? `RPS_OPT_MAX : opt_count);
  assign neg_want  = foreign_object_extensions & (max_power_over_5w | neg_opt_en);

  rps_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .restart   (restart),
    .ms_r      (ms)
  );

  // ----------------------------------------------------------------
  // configuration fields and hold-off clamp
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_neg_r    <= 1'b0;
      cfg_pol_r    <= 1'b0;
      cfg_depth_r  <= `RPS_DEPTH_ZERO;
      holdoff_ms_r <= `RPS_HOLDOFF_MIN;
    end else begin
      cfg_neg_r   <= neg_want;
      cfg_pol_r   <= foreign_object_extensions ? cfg_polarity : 1'b0;
      cfg_depth_r <= foreign_object_extensions ? cfg_depth : `RPS_DEPTH_ZERO;
      if (holdoff_req_ms < `RPS_HOLDOFF_MIN)
        holdoff_ms_r <= `RPS_HOLDOFF_MIN;
      else if (holdoff_req_ms > `RPS_HOLDOFF_MAX)
        holdoff_ms_r <= `RPS_HOLDOFF_MAX;
      else
        holdoff_ms_r <= holdoff_req_ms;
    end
  end

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r      <= PH_SEL;
      step_r       <= ST_ID;
      busy_r       <= 1'b0;
      rise_seen_r  <= 1'b0;
      opt_done_r   <= `RPS_CNT_ZERO;
      pkt_req_r    <= 1'b0;
      pkt_type_r   <= `RPS_PKT_NONE;
      con_guar_r   <= `RPS_GUAR_5W;
      con_max_r    <= 6'h00;
      con_rp_hdr_r <= `RPS_RP_HDR_8BIT;
      con_pol_r    <= 1'b0;
      con_depth_r  <= `RPS_DEPTH_ZERO;
      tmp_guar_r   <= `RPS_GUAR_5W;
      tmp_max_r    <= 6'h00;
      tmp_rp_hdr_r <= `RPS_RP_HDR_8BIT;
      tmp_pol_r    <= 1'b0;
      tmp_depth_r  <= `RPS_DEPTH_ZERO;
    end else begin
      pkt_req_r <= 1'b0;
      if (pkt_done)
        busy_r <= 1'b0;
      if (coil_half_rise)
        rise_seen_r <= 1'b1;
      // removal or a new power signal pulls back to selection at once
      if (power_removed || !comm_ready || (power_applied && phase_r != PH_SEL)) begin
        phase_r     <= PH_SEL;
        step_r      <= ST_ID;
        busy_r      <= 1'b0;
        opt_done_r  <= `RPS_CNT_ZERO;
        pkt_type_r  <= `RPS_PKT_NONE;
        rise_seen_r <= coil_half_rise;
      end else begin
        case (phase_r)
          PH_SEL: begin
            // selection never transmits; leaving it sends the first packet
            if (vr_ok && (rise_seen_r || coil_half_rise) && !coil_half_rise
                && ms >= `RPS_T_WAKE_MS) begin
              phase_r    <= PH_PING;
              pkt_req_r  <= 1'b1;
              busy_r     <= 1'b1;
              pkt_type_r <= end_xfer_req ? `RPS_PKT_ENDXFER : `RPS_PKT_SIGSTR;
            end
          end
          PH_PING: begin
            if (pkt_done && pkt_type_r == `RPS_PKT_SIGSTR) begin
              phase_r    <= PH_IDCFG;
              step_r     <= ST_ID;
              opt_done_r <= `RPS_CNT_ZERO;
            end else if (spaced && pkt_type_r == `RPS_PKT_ENDXFER) begin
              // the far side may have missed the first one
              pkt_req_r <= 1'b1;
              busy_r    <= 1'b1;
            end
          end
          PH_IDCFG: begin
            case (step_r)
              ST_ID, ST_XID, ST_OPT, ST_CFG: begin
                if (pkt_done) begin
                  case (step_r)
                    ST_ID: begin
                      if (ext_id)
                        step_r <= ST_XID;
                      else
                        step_r <= (opt_limit != `RPS_CNT_ZERO) ? ST_OPT : ST_CFG;
                    end
                    ST_XID: begin
                      step_r <= (opt_limit != `RPS_CNT_ZERO) ? ST_OPT : ST_CFG;
                    end
                    ST_OPT: begin
                      opt_done_r <= opt_done_r + `RPS_CNT_ONE;
                      if (opt_done_r + `RPS_CNT_ONE >= opt_limit)
                        step_r <= ST_CFG;
                    end
                    default: begin
                      // contract built as configuration completes
                      con_guar_r   <= `RPS_GUAR_5W;
                      con_max_r    <= cfg_max_power;
                      con_rp_hdr_r <= `RPS_RP_HDR_8BIT;
                      con_pol_r    <= cfg_pol_r;
                      con_depth_r  <= cfg_depth_r;
                      if (cfg_neg_r)
                        step_r <= ST_WAIT;
                      else
                        phase_r <= PH_XFER;
                    end
                  endcase
                end else if (spaced && !pkt_req_r) begin
                  pkt_req_r <= 1'b1;
                  busy_r    <= 1'b1;
                  case (step_r)
                    ST_ID:   pkt_type_r <= `RPS_PKT_IDENT;
                    ST_XID:  pkt_type_r <= `RPS_PKT_XIDENT;
                    ST_OPT: begin
                      if (holdoff_en && opt_done_r == `RPS_CNT_ZERO)
                        pkt_type_r <= `RPS_PKT_HOLDOFF;
                      else
                        pkt_type_r <= `RPS_PKT_PROP;
                    end
                    default: pkt_type_r <= `RPS_PKT_CONFIG;
                  endcase
                end
              end
              ST_WAIT: begin
                if (ack_start) begin
                  phase_r      <= PH_NEG;
                  tmp_guar_r   <= con_guar_r;
                  tmp_max_r    <= con_max_r;
                  tmp_rp_hdr_r <= con_rp_hdr_r;
                  tmp_pol_r    <= con_pol_r;
                  tmp_depth_r  <= con_depth_r;
                end else if (ms >= `RPS_T_RSP_MS) begin
                  con_guar_r <= `RPS_GUAR_5W;
                  phase_r    <= PH_XFER;
                end
              end
              default: step_r <= ST_ID;
            endcase
          end
          // negotiation exchanges are handled by the request engine
          PH_NEG, PH_CAL, PH_XFER, PH_RENEG: begin
            phase_r <= phase_r;
          end
          default: begin
            phase_r <= PH_SEL;
          end
        endcase
      end
    end
  end

endmodule // rps_sequencer

// *** testbench/rps_mod_model.sv ***
// modulator stand-in: ends each requested packet after a set length
module rps_mod_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       pkt_req_r,
  input  wire logic [7:0] pkt_len,
  output logic            pkt_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  logic       busy_r;
  // length is a port so the bench can play a slow modulator too
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {busy_r, cnt_r, pkt_done} <= '0;
    end else begin
      pkt_done <= busy_r && cnt_r == pkt_len;
      busy_r <= pkt_req_r || (busy_r && cnt_r != pkt_len);
      cnt_r <= pkt_req_r ? 8'h00 : cnt_r + 8'h01;
    end
  end
endmodule // rps_mod_model

// *** testbench/rps_seq_props.sv ***
// concurrent checks for the receiver phase sequencer
`include "rps_map.vh"
module rps_seq_props #(
  parameter [`RPS_DIV_W-1:0] MS_CYCLES = `RPS_MS_CYCLES
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       power_removed,
  input wire logic       power_applied,
  input wire logic       comm_ready,
  input wire logic [7:0] holdoff_req_ms,
  input wire logic       foreign_object_extensions,
  input wire logic       pkt_done,
  input wire logic [6:0] phase_r,
  input wire logic       pkt_req_r,
  input wire logic [3:0] pkt_type_r,
  input wire logic       cfg_neg_r,
  input wire logic [7:0] holdoff_ms_r,
  input wire logic [5:0] con_guar_r,
  input wire logic [5:0] con_max_r,
  input wire logic [5:0] tmp_guar_r,
  input wire logic [5:0] tmp_max_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // saturating so a long idle never wraps into a false pass
  int gap_r;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) gap_r <= 0;
    else if (pkt_done) gap_r <= 0;
    else if (gap_r < 6 * MS_CYCLES) gap_r <= gap_r + 1;
  end
  function automatic logic [7:0] clampv(input logic [7:0] v);
    if (v < `RPS_HOLDOFF_MIN) return `RPS_HOLDOFF_MIN;
    return (v > `RPS_HOLDOFF_MAX) ? `RPS_HOLDOFF_MAX : v;
  endfunction
  property p_sel_quiet;
    phase_r == 7'h01 && $past(phase_r) == 7'h01 |-> !pkt_req_r; endproperty
  a_sel_quiet: assert property (p_sel_quiet) else $error("request in selection");
  property p_not_ready;
    !comm_ready |=> phase_r == 7'h01; endproperty
  a_not_ready: assert property (p_not_ready) else $error("left selection unready");
  property p_one_hot;
    $onehot(phase_r); endproperty
  a_one_hot: assert property (p_one_hot) else $error("phase not one-hot");
  property p_to_idcfg;
    pkt_done && phase_r == 7'h02 && pkt_type_r == `RPS_PKT_SIGSTR && comm_ready
      && !power_removed && !power_applied |=> phase_r == 7'h04; endproperty
  a_to_idcfg: assert property (p_to_idcfg) else $error("no advance after sigstr");
  property p_holdoff;
    1'b1 |=> holdoff_ms_r == clampv($past(holdoff_req_ms)); endproperty
  a_holdoff: assert property (p_holdoff) else $error("hold-off out of bounds");
  property p_silent;
    pkt_req_r && phase_r == 7'h04 |-> gap_r >= 6 * MS_CYCLES; endproperty
  a_silent: assert property (p_silent) else $error("silent time broken");
  property p_no_prop;
    foreign_object_extensions && pkt_req_r |-> pkt_type_r != `RPS_PKT_PROP; endproperty
  a_no_prop: assert property (p_no_prop) else $error("proprietary with ext");
  property p_neg_clear;
    pkt_req_r && pkt_type_r == `RPS_PKT_CONFIG && !foreign_object_extensions |-> !cfg_neg_r;
  endproperty
  a_neg_clear: assert property (p_neg_clear) else $error("neg set without ext");
  property p_tmp_copy;
    $rose(phase_r[3]) |-> tmp_guar_r == con_guar_r && tmp_max_r == con_max_r; endproperty
  a_tmp_copy: assert property (p_tmp_copy) else $error("temp contract not copied");
  property p_removed;
    power_removed |=> phase_r == 7'h01; endproperty
  a_removed: assert property (p_removed) else $error("no return to selection");
  c_ping: cover property ($rose(phase_r[1]));
  c_neg: cover property ($rose(phase_r[3]));
  c_xfer: cover property ($rose(phase_r[5]));
endmodule // rps_seq_props

bind rps_sequencer rps_seq_props #(.MS_CYCLES(MS_CYCLES)) u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .power_removed(power_removed),
  .power_applied(power_applied),
  .comm_ready(comm_ready), .holdoff_req_ms(holdoff_req_ms),
  .foreign_object_extensions(foreign_object_extensions), .pkt_done(pkt_done),
  .phase_r(phase_r), .pkt_req_r(pkt_req_r), .pkt_type_r(pkt_type_r), .cfg_neg_r(cfg_neg_r),
  .holdoff_ms_r(holdoff_ms_r), .con_guar_r(con_guar_r), .con_max_r(con_max_r),
  .tmp_guar_r(tmp_guar_r), .tmp_max_r(tmp_max_r));

// *** testbench/receiver_phase_sequencer_tb.sv ***
// self-checking bench for the receiver phase sequencer
`include "rps_map.vh"
module receiver_phase_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic ref_clk, reset_n, power_applied, power_removed, coil_half_rise, comm_ready, vr_ok;
  logic end_xfer_req, ext_id, foreign_object_extensions, max_power_over_5w, holdoff_en;
  logic ack_start, cfg_polarity, neg_opt_en;
  logic [2:0] opt_count;
  logic [7:0] holdoff_req_ms, pkt_len;
  logic [5:0] cfg_max_power;
  logic [1:0] cfg_depth;
  wire pkt_done, pkt_req_r, cfg_neg_r, cfg_pol_r, con_pol_r, tmp_pol_r;
  wire [6:0] phase_r;
  wire [3:0] pkt_type_r;
  wire [1:0] cfg_depth_r, con_depth_r, tmp_depth_r;
  wire [7:0] holdoff_ms_r, con_rp_hdr_r, tmp_rp_hdr_r;
  wire [5:0] con_guar_r, con_max_r, tmp_guar_r, tmp_max_r;
  int errors, checks_done, cyc, n;
  rps_sequencer #(.MS_CYCLES(17'h0000A)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .power_applied(power_applied),
    .power_removed(power_removed), .coil_half_rise(coil_half_rise), .comm_ready(comm_ready),
    .vr_ok(vr_ok), .end_xfer_req(end_xfer_req), .ext_id(ext_id),
    .foreign_object_extensions(foreign_object_extensions),
    .max_power_over_5w(max_power_over_5w), .neg_opt_en(neg_opt_en), .holdoff_en(holdoff_en),
    .opt_count(opt_count), .holdoff_req_ms(holdoff_req_ms), .cfg_max_power(cfg_max_power),
    .cfg_polarity(cfg_polarity), .cfg_depth(cfg_depth), .pkt_done(pkt_done),
    .ack_start(ack_start), .phase_r(phase_r), .pkt_req_r(pkt_req_r), .pkt_type_r(pkt_type_r),
    .cfg_neg_r(cfg_neg_r), .cfg_pol_r(cfg_pol_r), .cfg_depth_r(cfg_depth_r),
    .holdoff_ms_r(holdoff_ms_r), .con_guar_r(con_guar_r), .con_max_r(con_max_r),
    .con_rp_hdr_r(con_rp_hdr_r), .con_pol_r(con_pol_r), .con_depth_r(con_depth_r),
    .tmp_guar_r(tmp_guar_r), .tmp_max_r(tmp_max_r), .tmp_rp_hdr_r(tmp_rp_hdr_r),
    .tmp_pol_r(tmp_pol_r), .tmp_depth_r(tmp_depth_r));
  rps_mod_model far (.ref_clk(ref_clk), .reset_n(reset_n), .pkt_req_r(pkt_req_r),
    .pkt_len(pkt_len), .pkt_done(pkt_done));
  task automatic close_out();
    if (errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic poke();
    power_applied = 1'b1;
    coil_half_rise = 1'b1;
    tick(1);
    power_applied = 1'b0;
    coil_half_rise = 1'b0;
    for (n = 0; pkt_req_r !== 1'b1 && n < 700; n++) tick(1);
  endtask
  task automatic start_ping(input logic [3:0] t);
    poke();
    chk(n >= 39*MS && n <= 64*MS && pkt_type_r === t && phase_r === 7'h02, "ping entry");
    for (n = 0; pkt_done !== 1'b1 && n < 400; n++) tick(1);
  endtask
  task automatic get_pkt(input logic [3:0] t);
    for (n = 0; pkt_req_r !== 1'b1 && n < 300; n++) tick(1);
    chk(pkt_type_r === t && n >= 6 * MS && n <= 19 * MS, "packet kind or spacing");
    for (n = 0; pkt_done !== 1'b1 && n < 400; n++) tick(1);
  endtask
  task automatic go_sel();
    power_removed = 1'b1;
    tick(1);
    power_removed = 1'b0;
    chk(phase_r === 7'h01, "not back in selection");
  endtask
  task automatic s_quiet();
    comm_ready = 1'b0;
    poke();
    chk(n == 700 && phase_r === 7'h01, "request while unready");
    comm_ready = 1'b1;
    vr_ok = 1'b0;
    poke();
    chk(n == 700 && phase_r === 7'h01, "request with low voltage");
    go_sel();
    vr_ok = 1'b1;
  endtask
  task automatic s_full();
    ext_id = 1'b1;
    opt_count = 3'h7;
    cfg_max_power = 6'h15;
    cfg_polarity = 1'b1;
    cfg_depth = 2'h3;
    start_ping(`RPS_PKT_SIGSTR);
    tick(1);
    chk(phase_r === 7'h04, "no advance after signal strength");
    get_pkt(`RPS_PKT_IDENT);
    get_pkt(`RPS_PKT_XIDENT);
    repeat (6) get_pkt(`RPS_PKT_PROP);
    get_pkt(`RPS_PKT_CONFIG);
    chk(cfg_neg_r === 1'b0 && cfg_pol_r === 1'b0 && cfg_depth_r === 2'h0, "config bits");
    tick(1);
    chk(phase_r === 7'h20 && con_max_r === 6'h15, "power transfer entry");
    chk(con_guar_r === 6'h0A && con_rp_hdr_r === 8'h04, "initial contract");
    chk(con_pol_r === 1'b0 && con_depth_r === 2'h0, "contract fsk fields");
    go_sel();
  endtask
  task automatic s_endx();
    end_xfer_req = 1'b1;
    pkt_len = 8'h96;
    start_ping(`RPS_PKT_ENDXFER);
    repeat (2) get_pkt(`RPS_PKT_ENDXFER);
    chk(phase_r === 7'h02, "left ping after end-transfer");
    power_applied = 1'b1;
    tick(1);
    power_applied = 1'b0;
    chk(phase_r === 7'h01, "power signal did not force selection");
    end_xfer_req = 1'b0;
    pkt_len = 8'h1E;
    go_sel();
  endtask
  task automatic s_ext(input bit ack, input logic [7:0] hreq, input logic [7:0] hexp);
    foreign_object_extensions = 1'b1;
    max_power_over_5w = ack;
    neg_opt_en = !ack;
    holdoff_en = 1'b1;
    ext_id = 1'b0;
    holdoff_req_ms = hreq;
    start_ping(`RPS_PKT_SIGSTR);
    get_pkt(`RPS_PKT_IDENT);
    get_pkt(`RPS_PKT_HOLDOFF);
    chk(holdoff_ms_r === hexp, "hold-off value");
    get_pkt(`RPS_PKT_CONFIG);
    chk(cfg_neg_r === 1'b1, "neg flag clear");
    chk(cfg_pol_r === 1'b1 && cfg_depth_r === 2'h3, "config fields with ext");
    if (ack) begin
      tick(50);
      ack_start = 1'b1;
      tick(1);
      ack_start = 1'b0;
      chk(phase_r === 7'h08 && tmp_max_r === 6'h15 && tmp_guar_r === 6'h0A, "negotiation");
      chk(tmp_pol_r === 1'b1 && tmp_depth_r === 2'h3 && tmp_rp_hdr_r === 8'h04, "temp copy");
      chk(con_pol_r === 1'b1 && con_depth_r === 2'h3, "contract fsk fields");
    end else begin
      for (n = 0; phase_r === 7'h04 && n < 600; n++) tick(1);
      chk(phase_r === 7'h20 && n >= 15 * MS && con_guar_r === 6'h0A, "timeout path");
    end
    go_sel();
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    reset_n = 1'b0;
    {power_applied, power_removed, coil_half_rise, end_xfer_req, ext_id} = '0;
    {foreign_object_extensions, max_power_over_5w, holdoff_en, ack_start, cfg_polarity} = '0;
    comm_ready = 1'b1;
    vr_ok = 1'b1;
    opt_count = 3'h1;
    neg_opt_en = 1'b0;
    holdoff_req_ms = 8'h10;
    pkt_len = 8'h1E;
    cfg_max_power = 6'h0C;
    cfg_depth = 2'h0;
    tick(4);
    reset_n = 1'b1;
    tick(1);
    chk(phase_r === 7'h01 && pkt_type_r === 4'h0 && con_guar_r === 6'h0A, "reset state");
    s_quiet();
    s_full();
    s_endx();
    s_ext(1'b0, 8'hF0, 8'hCD);
    s_ext(1'b1, 8'h02, 8'h05);
    close_out();
  end
endmodule // receiver_phase_sequencer_tb
